// ===== emii_phy_model.sv
// external phy model: nibble clocks, receive driver, transmit capture
`timescale 1ns/1ps
module emii_phy_model (
    // clocks
    output logic             tx_clk,
    output logic             rx_clk,
    // transmit pins
    input  wire logic [3:0]  txd,
    input  wire logic        tx_en,
    // receive pins
    output logic [3:0]       rxd,
    output logic             rx_dv,
    output logic             rx_er,
    output logic             crs,
    output logic             col
);
    logic [3:0] seen_txd;
    logic       seen_tx_en;
    // rx offset in phase so the two clocks never share an edge
    initial begin
        {tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col} = 10'h000;
        fork
            forever #80 tx_clk = ~tx_clk;
            #37 forever #80 rx_clk = ~rx_clk;
        join
    end
    always @(posedge tx_clk) {seen_tx_en, seen_txd} <= {tx_en, txd};
    // one nibble under carrier; then every pin falls back to its pull-down
    task automatic rx_nibble(input logic [3:0] nib, input logic er, input logic c);
        @(negedge rx_clk);
        {crs, col, rx_er, rx_dv, rxd} = {1'h1, c, er, 1'h1, nib};
        @(negedge rx_clk);
        {crs, col, rx_er, rx_dv, rxd} = 8'h00;
    endtask : rx_nibble
endmodule : emii_phy_model

// ===== emii_pkg.sv
// package for the external media-independent interface port
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// [RULE1] phy supplies 25 or 2.5 MHz clocks; the phy model toggles both every 80 ns, giving 6.25 MHz
// [RULE2] phy accepts transmit nibble as line data
// [RULE3] transmit nibble zero when internal phy selected
// [RULE4] transmit enable only with valid nibble
// [RULE5] transmit enable zero when internal phy selected
// [RULE6] phy flags receive error within frame
// [RULE7] phy asserts collision on medium collision
// [RULE8] phy asserts carrier sense on carrier
// [RULE9] phy drives receive nibble data
// [RULE10] receive valid marks decoded nibbles exactly
// [RULE11] select one: management data pin bidirectional
// [RULE12] select one: drive management clock pin
// [RULE13] select zero: data released, clock low
// [RULE14] management data pin sampled as strap
// [RULE15] strap latched once after reset release
// [RULE16] transmit on tx clock, receive on rx clock
package emii_pkg;

    localparam int          NIBBLE_W      = 4;
    localparam logic [3:0]  NIBBLE_RESET  = 4'h0;
    localparam int          SYNC_STAGES   = 2;
    // cycles after reset release before the strap is captured
    localparam logic [1:0]  STRAP_DELAY   = 2'h3;

    typedef struct packed {
        logic                en;
        logic [NIBBLE_W-1:0] data;
    } emii_tx_t;

    typedef struct packed {
        logic                dv;
        logic                er;
        logic [NIBBLE_W-1:0] data;
    } emii_rx_t;

    typedef struct packed {
        logic crs;
        logic col;
    } emii_line_t;

endpackage : emii_pkg

// ===== emii_port.sv
// external media-independent interface port, mac side
`timescale 1ns/1ps
module emii_port
    import emii_pkg::*;
(
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                nrst,
    // configuration
    input  wire logic                ext_phy_select,
    input  wire logic                mgmt_port_select,
    // mac transmit side
    input  wire logic                mac_tx_en,
    input  wire logic [NIBBLE_W-1:0] mac_txd,
    output logic                     mac_tx_take,
    // mac receive side
    output emii_rx_t                 mac_rx,
    output logic                     mac_rx_strobe,
    output emii_line_t               mac_line,
    // mac management side
    input  wire logic                mac_mdc,
    input  wire logic                mac_mdio_out,
    input  wire logic                mac_mdio_oe,
    output logic                     mac_mdio_in,
    output logic                     external_phy_present_strap,
    // mii pins
    input  wire logic                tx_clk,
    output logic [NIBBLE_W-1:0]      txd,
    output logic                     tx_en,
    input  wire logic                rx_clk,
    input  wire logic [NIBBLE_W-1:0] rxd,
    input  wire logic                rx_dv,
    input  wire logic                rx_er,
    input  wire logic                crs,
    input  wire logic                col,
    output logic                     mdc,
    input  wire logic                mdio_i,
    output logic                     mdio_o,
    output logic                     mdio_oe
);
    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    localparam int SW = 2 + 2 + NIBBLE_W + 3;
    logic [SW-1:0] sync_in;
    logic [SW-1:0] sync_out;
    logic          s_txclk, s_rxclk, s_dv, s_er, s_crs, s_col, s_mdio;
    logic [NIBBLE_W-1:0] s_rxd;

    assign sync_in = {tx_clk, rx_clk, rx_dv, rx_er, rxd, crs, col, mdio_i};

    emii_sync #(.W(SW)) u_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .din     (sync_in),
        .dout    (sync_out)
    );

    assign {s_txclk, s_rxclk, s_dv, s_er, s_rxd, s_crs, s_col, s_mdio} = sync_out;

    //------------------------------------------------------------
    // clock edge detection
    //------------------------------------------------------------
    logic txclk_d, rxclk_d;
    logic tx_rise, rx_rise;

    // mii drives on rising tx clock; phy samples on the next rising edge
    assign tx_rise = s_txclk & ~txclk_d;
    // phy launches on falling rx clock, so rising edge sits mid-eye after sync delay
    assign rx_rise = s_rxclk & ~rxclk_d;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            txclk_d <= 1'b0;
            rxclk_d <= 1'b0;
        end else begin
            txclk_d <= s_txclk;
            rxclk_d <= s_rxclk;
        end
    end

    //------------------------------------------------------------
    // transmit path
    //------------------------------------------------------------
    emii_tx_t tx_q, next_tx;

    always_comb begin
        next_tx = tx_q;
        if (!ext_phy_select) begin
            next_tx.en   = 1'b0;                  // [RULE5]
            next_tx.data = NIBBLE_RESET;          // [RULE3]
        end else if (tx_rise) begin               // [RULE16]
            next_tx.en   = mac_tx_en;             // [RULE4]
            next_tx.data = mac_tx_en ? mac_txd : NIBBLE_RESET;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_q <= '0;
        end else begin
            tx_q <= next_tx;
        end
    end

    assign txd         = tx_q.data;
    assign tx_en       = tx_q.en;
    // mac must hold its nibble until taken; stalls the mac at line rate
    assign mac_tx_take = ext_phy_select & tx_rise;

    //------------------------------------------------------------
    // receive path
    //------------------------------------------------------------
    emii_rx_t   rx_q, next_rx;
    emii_line_t line_q, next_line;
    logic       strobe_q, next_strobe;

    always_comb begin
        next_rx     = rx_q;
        next_strobe = 1'b0;
        next_line.crs = s_crs & ext_phy_select;   // [RULE8]
        next_line.col = s_col & ext_phy_select;   // [RULE7]
        if (ext_phy_select && rx_rise) begin      // [RULE16]
            next_rx.dv   = s_dv;                  // [RULE10]
            next_rx.er   = s_er;                  // [RULE6]
            next_rx.data = s_rxd;                 // [RULE9]
            next_strobe  = s_dv;
        end else if (!ext_phy_select) begin
            next_rx = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_q     <= '0;
            line_q   <= '0;
            strobe_q <= 1'b0;
        end else begin
            rx_q     <= next_rx;
            line_q   <= next_line;
            strobe_q <= next_strobe;
        end
    end

    assign mac_rx        = rx_q;
    assign mac_line      = line_q;
    assign mac_rx_strobe = strobe_q;

    //------------------------------------------------------------
    // management pins
    //------------------------------------------------------------
    logic mdc_q, mdio_o_q, mdio_oe_q, mdio_in_q;
    logic next_mdc, next_mdio_o, next_mdio_oe, next_mdio_in;

    always_comb begin
        if (mgmt_port_select) begin
            next_mdc     = mac_mdc;               // [RULE12]
            next_mdio_o  = mac_mdio_out;          // [RULE11]
            next_mdio_oe = mac_mdio_oe;           // [RULE11]
            next_mdio_in = s_mdio;                // [RULE11]
        end else begin
            next_mdc     = 1'b0;                  // [RULE13]
            next_mdio_o  = 1'b0;
            next_mdio_oe = 1'b0;                  // [RULE13]
            next_mdio_in = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mdc_q     <= 1'b0;
            mdio_o_q  <= 1'b0;
            mdio_oe_q <= 1'b0;
            mdio_in_q <= 1'b0;
        end else begin
            mdc_q     <= next_mdc;
            mdio_o_q  <= next_mdio_o;
            mdio_oe_q <= next_mdio_oe;
            mdio_in_q <= next_mdio_in;
        end
    end

    assign mdc         = mdc_q;
    assign mdio_o      = mdio_o_q;
    assign mdio_oe     = mdio_oe_q;
    assign mac_mdio_in = mdio_in_q;

    //------------------------------------------------------------
    // strap capture
    //------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_WAIT = 2'b01,
        ST_HELD = 2'b10
    } emii_strap_st_t;

    emii_strap_st_t strap_st, next_strap_st;
    logic [1:0]     strap_cnt, next_strap_cnt;
    logic           strap_q, next_strap;

    // waits for the synchroniser to fill before trusting the pin
    always_comb begin
        next_strap_st  = strap_st;
        next_strap_cnt = strap_cnt;
        next_strap     = strap_q;
        case (strap_st)
            ST_WAIT: begin
                if (strap_cnt == STRAP_DELAY) begin
                    next_strap    = s_mdio;       // [RULE14]
                    next_strap_st = ST_HELD;      // [RULE15]
                end else begin
                    next_strap_cnt = strap_cnt + 2'h1;
                end
            end
            ST_HELD: begin
                next_strap = strap_q;             // [RULE15]
            end
            default: begin
                next_strap_st  = ST_WAIT;
                next_strap_cnt = 2'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            strap_st  <= ST_WAIT;
            strap_cnt <= 2'h0;
            strap_q   <= 1'b0;
        end else begin
            strap_st  <= next_strap_st;
            strap_cnt <= next_strap_cnt;
            strap_q   <= next_strap;
        end
    end

    assign external_phy_present_strap = strap_q;

endmodule : emii_port

// ===== emii_port_sva.sv
// port assertions for emii_port
`timescale 1ns/1ps
module emii_port_sva
    import emii_pkg::*;
(
    // clock, reset, selects
    input wire logic          sys_clk,
    input wire logic          nrst,
    input wire logic          ext_phy_select,
    input wire logic          mgmt_port_select,
    // mac side
    input wire logic          mac_tx_en,
    input wire logic [3:0]    mac_txd,
    input wire logic          mac_tx_take,
    input wire emii_rx_t      mac_rx,
    input wire logic          mac_rx_strobe,
    input wire logic          mac_mdc,
    input wire logic          mac_mdio_out,
    input wire logic          mac_mdio_oe,
    // pins
    input wire logic [3:0]    txd,
    input wire logic          tx_en,
    input wire logic          mdc,
    input wire logic          mdio_o,
    input wire logic          mdio_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // two edges on the internal phy: the first has already forced the outputs idle
    sequence s_internal; !ext_phy_select ##1 !ext_phy_select; endsequence
    sequence s_take; mac_tx_take && ext_phy_select; endsequence
    a_txd_internal: assert property (s_internal |-> txd == 4'h0)
        else $error("txd not idle");
    a_txen_internal: assert property (s_internal |-> !tx_en)
        else $error("tx_en not idle");
    a_tx_capture: assert property (s_take |=> tx_en == $past(mac_tx_en)
        && txd == ($past(mac_tx_en) ? $past(mac_txd) : 4'h0)) else $error("tx nibble wrong");
    a_tx_hold: assert property (ext_phy_select && !mac_tx_take |=> $stable(txd))
        else $error("txd moved");
    a_rx_internal: assert property (s_internal |-> !mac_rx_strobe && mac_rx == 6'h00)
        else $error("rx not idle");
    a_mdc_follow: assert property (mgmt_port_select |=> mdc == $past(mac_mdc))
        else $error("mdc wrong");
    a_mdio_follow: assert property (mgmt_port_select |=> mdio_oe == $past(mac_mdio_oe)
        && mdio_o == $past(mac_mdio_out)) else $error("mdio drive wrong");
    a_mgmt_idle: assert property (!mgmt_port_select |=> !mdc && !mdio_oe)
        else $error("mgmt pins not idle");
endmodule : emii_port_sva
bind emii_port emii_port_sva i_sva (.*);

// ===== emii_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module emii_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    // levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;

    // meta is read only by the second stage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : emii_sync

// ===== tb.sv
// self-checking bench for emii_port
`timescale 1ns/1ps
module tb;
    import emii_pkg::*;
    logic       sys_clk = 1'h0, nrst = 1'h0, ext_phy_select = 1'h1, mgmt_port_select = 1'h0;
    logic       mac_tx_en = 1'h0, mac_mdc = 1'h0, mac_mdio_out = 1'h0, mac_mdio_oe = 1'h0;
    logic       phy_mdio_oe = 1'h1, phy_mdio = 1'h1, mac_tx_take, mac_rx_strobe, mac_mdio_in;
    logic       external_phy_present_strap, tx_clk, tx_en, rx_clk, rx_dv, rx_er, crs, col;
    logic       mdc, mdio_i, mdio_o, mdio_oe;
    logic [3:0] mac_txd = 4'h0, txd, rxd;
    emii_rx_t   mac_rx;
    emii_line_t mac_line;
    int         mismatches = 0, total_checks = 0, i;
    always #5 sys_clk = ~sys_clk;
    // pin level: our drive, else the phy's, else the pull-down
    assign mdio_i = mdio_oe ? mdio_o : (phy_mdio_oe ? phy_mdio : 1'h0);
    emii_port i_dut (.*);
    emii_phy_model i_phy (.*);
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'h1) begin
            mismatches++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    // reset with the strap at v, then flip the pin: the latched copy must not follow
    task automatic t_strap(input logic v);
        {nrst, phy_mdio_oe, phy_mdio} = {1'h0, 1'h1, v};
        repeat (4) @(negedge sys_clk);
        nrst = 1'h1;
        repeat (8) @(negedge sys_clk);
        check(external_phy_present_strap === v, "strap");
        phy_mdio = ~v;
        repeat (8) @(negedge sys_clk);
        check(external_phy_present_strap === v, "strap held");
        phy_mdio_oe = 1'h0;
    endtask : t_strap
    // back-to-back nibbles, the last slot idle
    task automatic t_tx();
        for (int k = 0; k < 3; k++) begin
            {mac_tx_en, mac_txd} = {k != 2, 4'hA ^ 4'(k * 5)};
            for (i = 0; i < 40 && mac_tx_take !== 1'h1; i++) @(negedge sys_clk);
            @(negedge sys_clk);
            check(i < 40 && {tx_en, txd} === {mac_tx_en, mac_tx_en ? mac_txd : 4'h0}, "tx");
            @(posedge tx_clk) #1;
            check({i_phy.seen_tx_en, i_phy.seen_txd} === {tx_en, txd}, "phy view");
            @(negedge sys_clk);
        end
        mac_tx_en = 1'h0;
    endtask : t_tx
    task automatic t_rx();
        fork i_phy.rx_nibble(4'hC, 1'h1, 1'h1); join_none
        for (i = 0; i < 60 && mac_rx_strobe !== 1'h1; i++) @(negedge sys_clk);
        check(mac_rx === 6'h3C && mac_line === 2'h3, "rx nibble");
        @(negedge sys_clk);
        check(mac_rx_strobe === 1'h0, "strobe width");
        wait fork;
        // the model returns on an rx clock edge; get back onto the falling system edge
        @(negedge sys_clk);
    endtask : t_rx
    // internal phy: pins idle and receive ignored with traffic on both sides
    task automatic t_internal();
        {ext_phy_select, mac_tx_en, mac_txd} = 6'h1F;
        fork
            i_phy.rx_nibble(4'h5, 1'h0, 1'h0);
            for (i = 0; i < 40; i++) begin
                @(negedge sys_clk);
                check({mac_rx_strobe, mac_rx, mac_line, tx_en, txd} === 14'h0000 || i < 2,
                      "internal");
            end
        join
        {ext_phy_select, mac_tx_en} = 2'h2;
    endtask : t_internal
    task automatic t_mgmt();
        {mgmt_port_select, mac_mdc, mac_mdio_oe, mac_mdio_out} = 4'hF;
        @(negedge sys_clk);
        check({mdc, mdio_oe, mdio_o} === 3'h7, "mgmt drive");
        // phy answers with the opposite of our last drive, so a stale loopback cannot pass
        {mac_mdio_oe, phy_mdio_oe, phy_mdio} = 3'h2;
        repeat (4) @(negedge sys_clk);
        check(mac_mdio_in === 1'h0 && mdio_oe === 1'h0, "mgmt read");
        mgmt_port_select = 1'h0;
        @(negedge sys_clk);
        check({mdc, mdio_oe} === 2'h0, "mgmt off");
        {mac_mdc, phy_mdio_oe} = 2'h0;
    endtask : t_mgmt
    initial begin
        t_strap(1'h1);
        t_tx();
        t_rx();
        t_internal();
        t_mgmt();
        t_strap(1'h0);
        complete_run();
    end
    // the sequence needs about 1.7 us
    initial begin
        #30000;
        mismatches++;
        complete_run();
    end
endmodule : tb
